// ===== rtl/dcf_fifo_top.sv
/*
 FIFO controller around a flip-flop memory: pointer store with synchronised
 pointer views, full/empty/nearly flags, error flags, standard and
 pass-through read modes and an optional output pipeline register in single-clock mode.
 Assumes one clock clk and writer/reader logic on that same clock; the
 configuration inputs are held static while the FIFO is in use.
*/
// Overview of operation
// RULE1: Write stores word when enabled and not full.
// RULE2: Enables held low before and during reset.
// RULE3: Enables held low two cycles after reset.
// RULE4: Read moves next word into output register.
// RULE5: Reset returns pointers and flags to initial.
// RULE6: Reset held at least five cycles.
// RULE7: Reset leaves memory and data output alone.
// RULE8: Reset forces empty flags high, full low.
// RULE9: Output-stage reset synchronously loads pipeline register.
// RULE10: Output-stage enable gates pipeline; reset wins.
// RULE11: Read data and parity driven synchronously.
// RULE12: Full when all entries used; blocks writes.
// RULE13: Nearly-full when free entries below threshold.
// RULE14: Nearly-empty when stored entries below threshold.
// RULE15: Empty when nothing stored; blocks reads.
// RULE16: Read pointer count exposed, wraps to zero.
// RULE17: Write pointer count exposed, wraps to zero.
// RULE18: Write while full raises write error.
// RULE19: Read while empty raises read error.
// RULE20: Standard mode: word appears after read enable.
// RULE21: Pass-through mode: first word appears unrequested.
// RULE22: Reader advances only when empty is low.
// RULE23: Pass-through only in dual-clock configuration.
// RULE24: Empty releases three cycles, four pass-through.
// RULE25: Full releases three cycles after a read.
// RULE26: Read error clears when enable or empty low.
// RULE27: Pointers cross through multi-stage gray synchronisers.
`timescale 1ns/1ps
`include "dcf_map.svh"

module dcf_fifo_store #(
   parameter int W = 36,
   parameter int D = 16,
   localparam int PW = $clog2(D) + 1
)(
   input wire logic clk,
   input wire logic rstn,
   input wire logic single_clock,
   input wire logic wr_valid,
   input wire logic [W-1:0] wr_data,
   output logic wr_ready,
   output logic rd_valid,
   output logic [W-1:0] rd_data,
   input wire logic rd_ready,
   input wire logic [PW-1:0] nf_thresh,
   input wire logic [PW-1:0] ne_thresh,
   output logic nearly_full,
   output logic nearly_empty,
   output logic [PW-1:0] wr_ptr,
   output logic [PW-1:0] rd_ptr
);

   // Binary to gray, so only one bit moves per step across the crossing.
   function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
      to_gray = b ^ (b >> 1);
   endfunction

   // Gray back to binary for the occupancy arithmetic.
   function automatic logic [PW-1:0] to_bin(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b = '0;
      b[PW-1] = g[PW-1];
      for (int i = PW - 2; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      to_bin = b;
   endfunction

   logic [W-1:0] mem_q [D]; // Storage, never cleared by reset.
   logic [PW-1:0] wptr_q; // Write pointer with wrap bit.
   logic [PW-1:0] rptr_q; // Read pointer with wrap bit.
   logic [PW-1:0] wptr_d, rptr_d; // Next write and read pointers.
   logic [PW-1:0] wsync1_q; // First stage, read only by the second.
   logic [PW-1:0] wsync2_q; // Write pointer as seen by the reader.
   logic [PW-1:0] rsync1_q; // First stage, read only by the second.
   logic [PW-1:0] rsync2_q; // Read pointer as seen by the writer.
   logic [PW-1:0] w_seen; // Gray write pointer the read side compares.
   logic [PW-1:0] r_seen; // Gray read pointer the write side compares.
   logic [PW-1:0] stored; // Entries the reader believes are present.
   logic [PW-1:0] free; // Entries the writer believes are free.
   logic full_q, empty_q, nfull_q, nempty_q; // Registered flags of the store.
   logic wr_fire, rd_fire; // Transfers accepted at this edge.

   assign wr_fire = wr_valid & ~full_q; // RULE1 RULE12
   assign rd_fire = rd_ready & ~empty_q; // RULE15
   assign wptr_d = wptr_q + {{(PW-1){1'b0}}, wr_fire};
   assign rptr_d = rptr_q + {{(PW-1){1'b0}}, rd_fire};

   // Single-clock mode compares the live next pointers, so flags carry no
   // latency; otherwise the synchronised copies are used.
   assign w_seen = single_clock ? to_gray(wptr_d) : wsync2_q; // RULE27
   assign r_seen = single_clock ? to_gray(rptr_d) : rsync2_q; // RULE27
   assign stored = to_bin(w_seen) - rptr_d;
   assign free = PW'(D) - (wptr_d - to_bin(r_seen));

   // Memory write; reset deliberately leaves contents intact.
   always_ff @(posedge clk)
   begin
      if (wr_fire)
         mem_q[wptr_q[PW-2:0]] <= wr_data; // RULE1 RULE7
   end

   // Pointers advance only on accepted transfers and wrap naturally.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wptr_q <= '0; // RULE5
         rptr_q <= '0; // RULE5
      end
      else
      begin
         wptr_q <= wptr_d; // RULE17
         rptr_q <= rptr_d; // RULE16
      end
   end

   // Two-stage gray crossings; they cost the release latency of the flags.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wsync1_q <= '0;
         wsync2_q <= '0;
         rsync1_q <= '0;
         rsync2_q <= '0;
      end
      else
      begin
         wsync1_q <= to_gray(wptr_q); // RULE27
         wsync2_q <= wsync1_q; // RULE24
         rsync1_q <= to_gray(rptr_q); // RULE27
         rsync2_q <= rsync1_q; // RULE25
      end
   end

   // Flags rise at once from the local pointer and fall after the crossing.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         empty_q <= 1'b1; // RULE8
         nempty_q <= 1'b1; // RULE8
         full_q <= 1'b0; // RULE8
         nfull_q <= 1'b0; // RULE8
      end
      else
      begin
         empty_q <= (to_gray(rptr_d) == w_seen); // RULE15 RULE24
         nempty_q <= (stored < ne_thresh); // RULE14
         full_q <= (to_gray(wptr_d) ==
            {~r_seen[PW-1:PW-2], r_seen[PW-3:0]}); // RULE12 RULE25
         nfull_q <= (free < nf_thresh); // RULE13
      end
   end

   assign wr_ready = ~full_q;
   assign rd_valid = ~empty_q;
   assign rd_data = mem_q[rptr_q[PW-2:0]];
   assign nearly_full = nfull_q;
   assign nearly_empty = nempty_q;
   assign wr_ptr = wptr_q;
   assign rd_ptr = rptr_q;

   a_full_blocks_write: assert property (@(posedge clk) disable iff (!rstn)
      full_q && wr_valid |=> $stable(wptr_q)) // RULE12
      else $error("Write pointer moved while full.");
   a_empty_blocks_read: assert property (@(posedge clk) disable iff (!rstn)
      empty_q && rd_ready |=> $stable(rptr_q)) // RULE15
      else $error("Read pointer moved while empty.");
   a_reset_flags: assert property (@(posedge clk)
      !rstn |=> empty_q && nempty_q && !full_q && !nfull_q) // RULE8
      else $error("Flags wrong after reset.");
   a_empty_release: assert property (@(posedge clk) disable iff (!rstn)
      !single_clock && empty_q && wr_fire && wptr_q == rptr_q &&
      wsync1_q == to_gray(wptr_q) && wsync2_q == wsync1_q
      |-> empty_q [*4] ##1 !empty_q) // RULE24
      else $error("Empty did not release three cycles after a write.");
   a_full_release: assert property (@(posedge clk) disable iff (!rstn)
      !single_clock && full_q && rd_fire && !wr_valid &&
      rsync1_q == to_gray(rptr_q) && rsync2_q == rsync1_q
      |-> full_q [*4] ##1 !full_q) // RULE25
      else $error("Full did not release three cycles after a read.");

endmodule // dcf_fifo_store

module dcf_fifo_top
   import dcf_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [`DCF_DATA_W-1:0] write_data_in,
   input wire logic [`DCF_PAR_W-1:0] write_parity_in,
   input wire logic write_enable,
   input wire logic read_enable,
   input wire logic single_clock_mode,
   input wire logic first_word_passthrough,
   input wire logic output_pipeline_enable,
   input wire logic output_stage_reset,
   input wire logic output_stage_clock_enable,
   input wire logic [`DCF_PTR_W-1:0] nearly_full_threshold,
   input wire logic [`DCF_PTR_W-1:0] nearly_empty_threshold,
   output logic [`DCF_DATA_W-1:0] read_data_out,
   output logic [`DCF_PAR_W-1:0] read_parity_out,
   output logic full_flag,
   output logic empty_flag,
   output logic nearly_full_flag,
   output logic nearly_empty_flag,
   output logic [`DCF_CNT_W-1:0] read_pointer_count,
   output logic [`DCF_CNT_W-1:0] write_pointer_count,
   output logic write_error_flag,
   output logic read_error_flag
);

   dcf_mode_t read_mode; // Effective read mode.
   dcf_word_t store_word; // Word at the head of the store.
   dcf_word_t data_q; // Output register, not touched by reset.
   dcf_word_t pipe_q; // Optional pipeline stage after the output register.
   dcf_ptr_t wr_ptr, rd_ptr; // Store pointers with their wrap bits.
   logic store_ready, store_valid; // Store can take a word; store holds a word.
   logic fetch; // Head word moves into the output register.
   logic hold_valid_q; // Output register holds an unread word (pass-through).
   logic use_pipe; // Pipeline stage is in the output path.
   logic wr_err_q, rd_err_q; // Registered error flags.

   // Pass-through needs the crossing latency model, so it is refused in
   // single-clock operation and quietly falls back to standard mode.
   assign read_mode = (first_word_passthrough && !single_clock_mode) ?
      DCF_PASSTHROUGH : DCF_STANDARD; // RULE23
   assign use_pipe = single_clock_mode & output_pipeline_enable;

   // In standard mode only read enable fetches; in pass-through the
   // register refills itself whenever it is empty or being consumed.
   always_comb
   begin
      case (read_mode)
         DCF_STANDARD: fetch = read_enable & store_valid; // RULE4 RULE20
         DCF_PASSTHROUGH: fetch = store_valid & (~hold_valid_q | read_enable); // RULE21
         default: fetch = 1'b0;
      endcase
   end

   dcf_fifo_store #(.W(`DCF_WORD_W), .D(`DCF_DEPTH)) u_store (
      .clk(clk), .rstn(rstn), .single_clock(single_clock_mode),
      .wr_valid(write_enable), .wr_data({write_data_in, write_parity_in}),
      .wr_ready(store_ready), .rd_valid(store_valid), .rd_data(store_word),
      .rd_ready(fetch), .nf_thresh(nearly_full_threshold),
      .ne_thresh(nearly_empty_threshold), .nearly_full(nearly_full_flag),
      .nearly_empty(nearly_empty_flag), .wr_ptr(wr_ptr), .rd_ptr(rd_ptr)
   );

   // Output register loads only on a fetch; reset leaves it alone.
   always_ff @(posedge clk)
   begin
      if (fetch)
         data_q <= store_word; // RULE4 RULE7 RULE11
   end

   // Tracks whether the pass-through register still holds an unread word.
   always_ff @(posedge clk)
   begin
      if (!rstn)
         hold_valid_q <= 1'b0; // RULE5
      else if (read_mode != DCF_PASSTHROUGH)
         hold_valid_q <= 1'b0; // Standard mode never holds a word ahead.
      else if (fetch)
         hold_valid_q <= 1'b1; // RULE21
      else if (read_enable)
         hold_valid_q <= 1'b0; // RULE22
   end

   // Pipeline stage: its own reset wins over its clock enable.
   always_ff @(posedge clk)
   begin
      if (use_pipe && output_stage_reset)
         pipe_q <= `DCF_STAGE_RST_VAL; // RULE9
      else if (use_pipe && output_stage_clock_enable)
         pipe_q <= data_q; // RULE10
   end

   // Error flags follow the offending request; they drop as soon as the
   // enable or the matching full/empty flag goes low.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wr_err_q <= 1'b0; // RULE5
         rd_err_q <= 1'b0; // RULE5
      end
      else
      begin
         wr_err_q <= write_enable & ~store_ready; // RULE18
         rd_err_q <= read_enable & empty_flag; // RULE19 RULE26
      end
   end

   assign empty_flag = (read_mode == DCF_PASSTHROUGH) ? ~hold_valid_q : ~store_valid;
   assign full_flag = ~store_ready;
   assign {read_data_out, read_parity_out} = use_pipe ? pipe_q : data_q; // RULE11
   assign read_pointer_count = rd_ptr[`DCF_CNT_W-1:0]; // RULE16
   assign write_pointer_count = wr_ptr[`DCF_CNT_W-1:0]; // RULE17
   assign write_error_flag = wr_err_q;
   assign read_error_flag = rd_err_q;

   a_write_error_set: assert property (@(posedge clk) disable iff (!rstn)
      write_enable && full_flag |=> write_error_flag) // RULE18
      else $error("Write while full gave no write error.");
   a_read_error_clear: assert property (@(posedge clk) disable iff (!rstn)
      !read_enable || !empty_flag |=> !read_error_flag) // RULE26
      else $error("Read error did not clear.");
   a_read_error_set: assert property (@(posedge clk) disable iff (!rstn)
      read_enable && empty_flag |=> read_error_flag) // RULE19
      else $error("Read while empty gave no read error.");
   a_read_count_step: assert property (@(posedge clk) disable iff (!rstn)
      fetch |=> read_pointer_count == `DCF_CNT_W'($past(read_pointer_count) + 1)) // RULE16
      else $error("Read count did not step by one.");
   a_stage_reset: assert property (@(posedge clk)
      use_pipe && output_stage_reset |=> pipe_q == `DCF_STAGE_RST_VAL) // RULE9
      else $error("Output stage reset ignored.");
   a_first_word_fill: assert property (@(posedge clk) disable iff (!rstn)
      read_mode == DCF_PASSTHROUGH && !hold_valid_q && store_valid
      |=> !empty_flag && data_q == $past(store_word)) // RULE21
      else $error("First word did not fall through.");

endmodule // dcf_fifo_top

// ===== rtl/dcf_map.svh
/*
 Constants of the dual-clock style FIFO: widths, depth, pointer sizes and
 the value loaded by the output-stage reset.
 Assumes it is included by its bare name; it holds definitions only.
*/
`ifndef DCF_MAP_SVH
`define DCF_MAP_SVH

// Data word width without parity.
`define DCF_DATA_W 32
// Parity bits carried beside each word.
`define DCF_PAR_W 4
// Stored word width, data and parity together.
`define DCF_WORD_W 36
// Number of entries in the buffer.
`define DCF_DEPTH 16
// Pointer width: index bits plus one wrap bit.
`define DCF_PTR_W 5
// Width of the exposed pointer counts.
`define DCF_CNT_W 4
// Value the output-stage reset loads into the pipeline register.
`define DCF_STAGE_RST_VAL 36'h0_0000_0000

`endif

// ===== rtl/dcf_pkg.sv
/*
 Types shared by the FIFO design: word, pointer, count and read mode.
 Assumes dcf_map.svh is reachable on the include path.
*/
`include "dcf_map.svh"

package dcf_pkg;

   // One stored entry, data in the upper bits and parity in the lower bits.
   typedef logic [`DCF_WORD_W-1:0] dcf_word_t;
   // Pointer with wrap bit.
   typedef logic [`DCF_PTR_W-1:0] dcf_ptr_t;
   // Exposed pointer count.
   typedef logic [`DCF_CNT_W-1:0] dcf_cnt_t;
   // How the first word after empty reaches the output.
   typedef enum logic {DCF_STANDARD, DCF_PASSTHROUGH} dcf_mode_t;

endpackage

// ===== verif/dcf_user_model.sv
/*
 Model of the user logic on both sides of the FIFO: a writer of numbered
 words and a reader, steered by the bench through wr_left, rd_left, rude.
 Assumes one clock shared with the FIFO and a synchronous low reset.
*/
`timescale 1ns/1ps
`include "dcf_map.svh"

module dcf_user_model
   import dcf_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic full_flag,
   input wire logic empty_flag,
   output logic [`DCF_DATA_W-1:0] write_data_in,
   output logic [`DCF_PAR_W-1:0] write_parity_in,
   output logic write_enable,
   output logic read_enable
);
   // Words still to write and to read; wr_n numbers the next word.
   int wr_left = 0;
   int rd_left = 0;
   int wr_n = 0;
   int hold = 2;
   // When set, requests ignore the flags so that refusals can be provoked.
   bit rude = 0;
   bit w_hit;
   bit r_hit;
   bit rs;

   // Everything idle at time zero.
   initial
   begin
      write_enable = 1'b0;
      read_enable = 1'b0;
      write_data_in = '0;
      write_parity_in = '0;
   end

   // Sample at the edge, drive 1 ns later so the FIFO sees settled inputs.
   always @(posedge clk)
   begin
      w_hit = write_enable && !full_flag;
      r_hit = read_enable && !empty_flag;
      rs = rstn;
      #1;
      wr_left -= w_hit;
      wr_n += w_hit;
      rd_left -= r_hit;
      // Enables stay low in reset and for two cycles after it.
      hold = !rs ? 2 : (hold > 0 ? hold - 1 : 0);
      write_enable = hold == 0 && wr_left > 0 && (!full_flag || rude);
      read_enable = hold == 0 && rd_left > 0 && (!empty_flag || rude);
      // An idle writer shows no stale word: the pattern flips each cycle.
      write_data_in = write_enable ? {16'h5a3c, 16'(wr_n)} : ~write_data_in;
      write_parity_in = 4'(wr_n) ^ 4'ha;
   end
endmodule // dcf_user_model

// ===== verif/testbench.sv
/*
 Self-checking bench for the FIFO top: reset, standard and pass-through
 reads, fill and drain with refusals, and the output pipeline stage.
 Assumes dcf_user_model stands in for the writer and the reader.
*/
`timescale 1ns/1ps
`include "dcf_map.svh"

module testbench
   import dcf_pkg::*;
;
   // Clock, reset and the static settings of the FIFO.
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic single_clock_mode = 1'b0;
   logic first_word_passthrough = 1'b0;
   logic output_pipeline_enable = 1'b0;
   logic output_stage_reset = 1'b0;
   logic output_stage_clock_enable = 1'b1;
   logic [`DCF_PTR_W-1:0] nearly_full_threshold = 5'h04;
   logic [`DCF_PTR_W-1:0] nearly_empty_threshold = 5'h04;
   // Traffic between the user model and the FIFO.
   logic [`DCF_DATA_W-1:0] write_data_in;
   logic [`DCF_PAR_W-1:0] write_parity_in;
   logic write_enable;
   logic read_enable;
   logic [`DCF_DATA_W-1:0] read_data_out;
   logic [`DCF_PAR_W-1:0] read_parity_out;
   logic full_flag;
   logic empty_flag;
   logic nearly_full_flag;
   logic nearly_empty_flag;
   logic [`DCF_CNT_W-1:0] read_pointer_count;
   logic [`DCF_CNT_W-1:0] write_pointer_count;
   logic write_error_flag;
   logic read_error_flag;
   // Tallies, cycle count, next expected word and word number at reset.
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;
   int rd_n = 0;
   int base = 0;

   dcf_fifo_top dcf_fifo_top_i (
      .clk, .rstn, .write_data_in, .write_parity_in, .write_enable, .read_enable,
      .single_clock_mode, .first_word_passthrough, .output_pipeline_enable,
      .output_stage_reset, .output_stage_clock_enable, .nearly_full_threshold,
      .nearly_empty_threshold, .read_data_out, .read_parity_out, .full_flag,
      .empty_flag, .nearly_full_flag, .nearly_empty_flag, .read_pointer_count,
      .write_pointer_count, .write_error_flag, .read_error_flag
   );

   dcf_user_model dcf_user_model_i (
      .clk, .rstn, .full_flag, .empty_flag, .write_data_in, .write_parity_in,
      .write_enable, .read_enable
   );

   // A 4 ns clock.
   always #2 clk = ~clk;

   // A hang counts as a mismatch; the run needs about 150 cycles.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         miscompares++;
         conclude();
      end
   end

   // Word number n as the user model writes it, data then parity.
   function automatic logic [35:0] word(input int n);
      return {16'h5a3c, 16'(n), 4'(n) ^ 4'ha};
   endfunction

   // Passes n edges and stops 1 ns after the last, where inputs change.
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Sets the user model's orders at an edge, before it drives at 1 ns.
   task go(input int w, input int r, input bit rude);
      @(posedge clk);
      dcf_user_model_i.wr_left = w;
      dcf_user_model_i.rd_left = r;
      dcf_user_model_i.rude = rude;
      #1;
   endtask

   task check(input string what, input logic [35:0] seen, input logic [35:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task conclude();
      if (miscompares == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Counts edges, the transfer edge first, until a flag drops; at most 12.
   task edges_to_low(input string what, input bit pick_full, input int exp);
      int n;
      n = 0;
      do
      begin
         tick(1);
         n++;
      end while ((pick_full ? full_flag : empty_flag) !== 1'b0 && n < 12);
      check(what, 36'(n), 36'(exp));
   endtask

   // Reads one word and compares it; the data stands, so two edges is safe.
   task read_one();
      go(0, 1, 0);
      tick(2);
      check("data", {read_data_out, read_parity_out}, word(rd_n));
      rd_n++;
   endtask

   // Reset for five edges with the user model idle, checked mid-reset.
   task do_reset();
      go(0, 0, 0);
      rstn = 1'b0;
      tick(5);
      check("reset flags", 36'({empty_flag, nearly_empty_flag, full_flag,
         nearly_full_flag, write_error_flag, read_error_flag}), 36'h30);
      check("reset counts", 36'({read_pointer_count, write_pointer_count}), 36'h0);
      if (rd_n > 0)
         check("kept data", {read_data_out, read_parity_out}, word(rd_n - 1));
      rstn = 1'b1;
      tick(2);
      base = dcf_user_model_i.wr_n;
      rd_n = base;
   endtask

   // Standard mode: a lone word waits in the store until it is asked for.
   task standard_flow();
      go(1, 0, 0);
      edges_to_low("empty release", 0, 4);
      read_one();
      check("counts", 36'({read_pointer_count, write_pointer_count}),
         36'({4'(rd_n - base), 4'(dcf_user_model_i.wr_n - base)}));
      check("empty again", 36'(empty_flag), 36'h1);
   endtask

   // Fill to refusal, then drain to refusal; both pointer counts wrap.
   task fill_drain();
      go(16, 0, 0);
      tick(24);
      check("full flags", 36'({full_flag, nearly_full_flag, nearly_empty_flag}),
         36'h6);
      go(1, 0, 1);
      tick(2);
      check("write refused", 36'({write_error_flag, write_pointer_count}),
         36'({1'b1, 4'(dcf_user_model_i.wr_n - base)}));
      go(0, 0, 0);
      tick(2);
      check("write error", 36'(write_error_flag), 36'h0);
      go(0, 1, 0);
      edges_to_low("full release", 1, 4);
      check("data", {read_data_out, read_parity_out}, word(rd_n));
      rd_n++;
      repeat (15) read_one();
      go(0, 1, 1);
      tick(2);
      check("read refused", 36'({read_error_flag, empty_flag, read_pointer_count}),
         36'({2'b11, 4'(rd_n - base)}));
      go(0, 0, 0);
      tick(2);
      check("read error", 36'(read_error_flag), 36'h0);
   endtask

   // Pass-through: the first word shows unasked, a read brings the next.
   task passthrough();
      first_word_passthrough = 1'b1;
      do_reset();
      go(1, 0, 0);
      edges_to_low("empty release", 0, 5);
      check("fall through", {read_data_out, read_parity_out}, word(rd_n));
      rd_n++;
      go(1, 0, 0);
      tick(8);
      read_one();
   endtask

   // Single clock with the output stage: no fall-through, enable, reset.
   task pipeline();
      do_reset();
      single_clock_mode = 1'b1;
      output_pipeline_enable = 1'b1;
      go(1, 0, 0);
      tick(3);
      check("no fall through", {read_data_out, read_parity_out}, word(rd_n - 1));
      output_stage_clock_enable = 1'b0;
      go(0, 1, 0);
      tick(3);
      check("stage held", {read_data_out, read_parity_out}, word(rd_n - 1));
      output_stage_clock_enable = 1'b1;
      tick(1);
      check("stage loaded", {read_data_out, read_parity_out}, word(rd_n));
      rd_n++;
      output_stage_reset = 1'b1;
      tick(1);
      check("stage reset", {read_data_out, read_parity_out}, `DCF_STAGE_RST_VAL);
   endtask

   // Main sequence.
   initial
   begin
      do_reset();
      standard_flow();
      fill_drain();
      passthrough();
      pipeline();
      conclude();
   end
endmodule // testbench
